// File: src/fhp_pkg.sv
// constants, types and register map of the frame header parser
package fhp_pkg;
   // register byte offsets on the avalon slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_FCF = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0c;
   localparam logic [7:0] REG_PAN = 8'h10;
   localparam logic [7:0] REG_SHORT = 8'h14;
   localparam logic [7:0] REG_EXT_LO = 8'h18;
   localparam logic [7:0] REG_EXT_HI = 8'h1c;
   // control register bit positions
   localparam int CTRL_AACK = 0;
   localparam int CTRL_ARET = 1;
   localparam int CTRL_UPLD = 2;
   localparam int CTRL_PEND = 3;
   localparam int CTRL_FVN_LSB = 4;
   localparam int CTRL_TX_GO = 6;
   localparam int CTRL_PTR_CLR = 7;
   localparam logic [1:0] FVN_MODE_RESET = 2'h1;
   // status register bit positions
   localparam int ST_CLS_LSB = 0;
   localparam int ST_RX_DONE = 2;
   localparam int ST_TX_DONE = 3;
   localparam int ST_ACK_OK = 4;
   localparam int ST_NO_ACK = 5;
   localparam int ST_BUSY = 6;
   // frame control field positions
   localparam int FCF_PEND = 4;
   localparam int FCF_ACK_REQ = 5;
   localparam int FCF_INTRA = 6;
   localparam int FCF_DST_LSB = 10;
   localparam int FCF_VER_LSB = 12;
   localparam int FCF_SRC_LSB = 14;
   // frame types, address modes and length classes
   localparam logic [2:0] TYPE_DATA = 3'h1;
   localparam logic [2:0] TYPE_ACK = 3'h2;
   localparam logic [2:0] TYPE_CMD = 3'h3;
   localparam logic [1:0] AM_NONE = 2'h0;
   localparam logic [1:0] AM_SHORT = 2'h2;
   localparam logic [1:0] AM_EXT = 2'h3;
   localparam logic [1:0] CLS_RESERVED = 2'h0;
   localparam logic [1:0] CLS_ACK = 2'h1;
   localparam logic [1:0] CLS_MPDU = 2'h2;
   localparam logic [6:0] LEN_ACK = 7'h05;
   localparam logic [6:0] LEN_MPDU_MIN = 7'h09;
   localparam logic [7:0] CMD_DATA_REQ = 8'h04;
   localparam logic [15:0] ID_BCAST = 16'hffff;
   // buffer indexes: phr, fcf low, fcf high, sequence, first address byte
   localparam logic [6:0] IDX_FCF_LO = 7'h01;
   localparam logic [6:0] IDX_FCF_HI = 7'h02;
   localparam logic [6:0] IDX_SEQ = 7'h03;
   localparam logic [6:0] IDX_ADDR = 7'h04;
   // acknowledge wait in the auto retry transmit mode
   localparam int CLK_MHZ = 50;
   localparam int ACK_WAIT_US = 864;
   localparam int ACK_WAIT_CYCLES = ACK_WAIT_US * CLK_MHZ;

   typedef enum logic [2:0] {ST_IDLE, ST_RX_BODY, ST_RX_EVAL, ST_TX_SEND, ST_ACK_WAIT} fhp_state_e;
   typedef logic [127:0][7:0] fhp_mem_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } fhp_avm_req_s;

   typedef struct packed {
      logic valid;
      logic first;
      logic [7:0] data;
   } fhp_byte_s;

   typedef struct packed {
      logic req;
      logic [15:0] fcf;
      logic [7:0] seq;
   } fhp_ack_s;
endpackage

// File: src/fhp_frame_header_parser.sv
// frame header parser: buffer, header decode, receive filter, ack and retry control
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module fhp_frame_header_parser #(
   parameter int ACK_WAIT_CYCLES = fhp_pkg::ACK_WAIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire fhp_pkg::fhp_avm_req_s avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire fhp_pkg::fhp_byte_s rx_in,
   output fhp_pkg::fhp_byte_s tx_out,
   input wire logic tx_ready,
   output fhp_pkg::fhp_ack_s ack_out,
   output logic rx_start_pulse,
   output logic rx_frame_pulse
);

   typedef struct packed {
      fhp_pkg::fhp_state_e state;
      logic waitreq;
      logic [31:0] rdata;
      logic auto_ack_receive_mode;
      logic auto_retry_transmit_mode;
      logic reserved_type_upload_enable;
      logic ack_pending_value;
      logic [1:0] version_accept_mode;
      logic [15:0] pan_id;
      logic [15:0] short_addr;
      logic [63:0] ext_addr;
      fhp_pkg::fhp_mem_t mem;
      logic [6:0] rd_ptr;
      logic [6:0] wr_ptr;
      logic [6:0] rx_len;
      logic [6:0] rx_cnt;
      logic [6:0] tx_idx;
      logic [7:0] tx_seq;
      logic aret_wait;
      logic [15:0] timer;
      logic [1:0] len_class;
      logic [15:0] last_fcf;
      logic [7:0] last_seq;
      logic rx_done;
      logic tx_done;
      logic ack_ok;
      logic no_ack;
      fhp_pkg::fhp_byte_s tx;
      fhp_pkg::fhp_ack_s ack;
      logic rx_start;
      logic rx_frame;
   } fhp_core_s;

   fhp_core_s s_reg;
   fhp_core_s s_next;

   // bytes taken by an address field with its pan id, by mode
   function automatic logic [6:0] fhp_addr_len(input logic [1:0] mode);
      case (mode)
         fhp_pkg::AM_SHORT: fhp_addr_len = 7'h04;
         fhp_pkg::AM_EXT: fhp_addr_len = 7'h0a;
         default: fhp_addr_len = 7'h00;
      endcase
   endfunction

   // little-endian 16-bit field from two buffer bytes
   function automatic logic [15:0] fhp_get16(input fhp_pkg::fhp_mem_t m, input logic [6:0] idx);
      fhp_get16 = {m[7'(idx + 7'h01)], m[idx]};
   endfunction

   // little-endian 64-bit field from eight buffer bytes
   function automatic logic [63:0] fhp_get64(input fhp_pkg::fhp_mem_t m, input logic [6:0] idx);
      logic [63:0] v;
      v = '0;
      for (int i = 0; i < 8; i++) begin
         v[8*i +: 8] = m[7'(idx + 7'(i))];
      end
      fhp_get64 = v;
   endfunction

   // length class of a psdu length
   function automatic logic [1:0] fhp_len_class(input logic [6:0] len);
      if (len == fhp_pkg::LEN_ACK) begin
         fhp_len_class = fhp_pkg::CLS_ACK;
      end else if (len >= fhp_pkg::LEN_MPDU_MIN) begin
         fhp_len_class = fhp_pkg::CLS_MPDU;
      end else begin
         fhp_len_class = fhp_pkg::CLS_RESERVED;
      end
   endfunction

   logic bus_req;
   logic bus_take;
   logic [31:0] rd_mux;
   logic [15:0] fcf;
   logic [2:0] ftype;
   logic [1:0] dst_mode;
   logic [1:0] src_mode;
   logic [1:0] fver;
   logic [6:0] src_len;
   logic [6:0] pay_idx;
   logic [15:0] dst_pan;
   logic [15:0] dst_short;
   logic type_ok;
   logic ver_ok;
   logic addr_ok;
   logic bcast;
   logic pass;
   logic data_req;
   logic want_ack;

   // header decode of the frame held in the buffer
   always_comb begin
      fcf = fhp_get16(s_reg.mem, fhp_pkg::IDX_FCF_LO);
      ftype = fcf[2:0];
      dst_mode = fcf[fhp_pkg::FCF_DST_LSB +: 2];
      src_mode = fcf[fhp_pkg::FCF_SRC_LSB +: 2];
      fver = fcf[fhp_pkg::FCF_VER_LSB +: 2];
      // source pan id dropped when compressed and both addresses present
      src_len = fhp_addr_len(src_mode);
      if (fcf[fhp_pkg::FCF_INTRA] && dst_mode != fhp_pkg::AM_NONE
            && src_len != 7'h00) begin
         src_len = 7'(src_len - 7'h02);
      end
      pay_idx = 7'(fhp_pkg::IDX_ADDR + fhp_addr_len(dst_mode) + src_len);
      dst_pan = fhp_get16(s_reg.mem, fhp_pkg::IDX_ADDR);
      dst_short = fhp_get16(s_reg.mem, 7'(fhp_pkg::IDX_ADDR + 7'h02));
      // reserved types only with upload enabled
      type_ok = (ftype <= fhp_pkg::TYPE_CMD)
         || s_reg.reserved_type_upload_enable;
      // mode 3 takes any version, else versions up to the mode
      ver_ok = (s_reg.version_accept_mode == 2'h3)
         || (fver <= s_reg.version_accept_mode);
      bcast = (dst_mode == fhp_pkg::AM_SHORT) && (dst_short == fhp_pkg::ID_BCAST);
      case (dst_mode)
         fhp_pkg::AM_SHORT: begin
            addr_ok = (dst_pan == s_reg.pan_id || dst_pan == fhp_pkg::ID_BCAST)
               && (dst_short == s_reg.short_addr || bcast);
         end
         fhp_pkg::AM_EXT: begin
            addr_ok = (dst_pan == s_reg.pan_id || dst_pan == fhp_pkg::ID_BCAST)
               && (fhp_get64(s_reg.mem, 7'(fhp_pkg::IDX_ADDR + 7'h02)) == s_reg.ext_addr);
         end
         fhp_pkg::AM_NONE: begin
            // only a source: its pan id must be ours
            addr_ok = (src_mode == fhp_pkg::AM_NONE) || (dst_pan == s_reg.pan_id);
         end
         default: addr_ok = 1'b0;
      endcase
      // filtering applies only in the auto ack receive mode
      if (s_reg.auto_ack_receive_mode) begin
         pass = type_ok && ver_ok && addr_ok
            && (fhp_len_class(s_reg.rx_len) != fhp_pkg::CLS_RESERVED);
      end else begin
         pass = 1'b1;
      end
      data_req = (ftype == fhp_pkg::TYPE_CMD) && (s_reg.mem[pay_idx] == fhp_pkg::CMD_DATA_REQ);
      want_ack = s_reg.auto_ack_receive_mode && pass && fcf[fhp_pkg::FCF_ACK_REQ] && !bcast
         && (ftype == fhp_pkg::TYPE_DATA || ftype == fhp_pkg::TYPE_CMD);
   end

   // register read mux; reserved bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avm_req.address)
         fhp_pkg::REG_CTRL: begin
            rd_mux[fhp_pkg::CTRL_AACK] = s_reg.auto_ack_receive_mode;
            rd_mux[fhp_pkg::CTRL_ARET] = s_reg.auto_retry_transmit_mode;
            rd_mux[fhp_pkg::CTRL_UPLD] = s_reg.reserved_type_upload_enable;
            rd_mux[fhp_pkg::CTRL_PEND] = s_reg.ack_pending_value;
            rd_mux[fhp_pkg::CTRL_FVN_LSB +: 2] = s_reg.version_accept_mode;
         end
         fhp_pkg::REG_STATUS: begin
            rd_mux[fhp_pkg::ST_CLS_LSB +: 2] = s_reg.len_class;
            rd_mux[fhp_pkg::ST_RX_DONE] = s_reg.rx_done;
            rd_mux[fhp_pkg::ST_TX_DONE] = s_reg.tx_done;
            rd_mux[fhp_pkg::ST_ACK_OK] = s_reg.ack_ok;
            rd_mux[fhp_pkg::ST_NO_ACK] = s_reg.no_ack;
            rd_mux[fhp_pkg::ST_BUSY] = (s_reg.state != fhp_pkg::ST_IDLE);
         end
         fhp_pkg::REG_FCF: rd_mux[23:0] = {s_reg.last_seq, s_reg.last_fcf};
         fhp_pkg::REG_DATA: rd_mux[7:0] = s_reg.mem[s_reg.rd_ptr];
         fhp_pkg::REG_PAN: rd_mux[15:0] = s_reg.pan_id;
         fhp_pkg::REG_SHORT: rd_mux[15:0] = s_reg.short_addr;
         fhp_pkg::REG_EXT_LO: rd_mux = s_reg.ext_addr[31:0];
         fhp_pkg::REG_EXT_HI: rd_mux = s_reg.ext_addr[63:32];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // next state: bus access first so hardware events set after a clear
   always_comb begin
      s_next = s_reg;
      s_next.rx_start = 1'b0;
      s_next.rx_frame = 1'b0;
      s_next.ack.req = 1'b0;
      bus_req = avm_req.read | avm_req.write;
      bus_take = bus_req & ~s_reg.waitreq;
      // one wait cycle, then a single ready cycle per request
      s_next.waitreq = ~(bus_req & s_reg.waitreq);
      if (avm_req.read && s_reg.waitreq) begin
         s_next.rdata = rd_mux;
      end
      if (bus_take && avm_req.read && avm_req.address == fhp_pkg::REG_DATA) begin
         s_next.rd_ptr = 7'(s_reg.rd_ptr + 7'h01);
      end
      if (bus_take && avm_req.write) begin
         case (avm_req.address)
            fhp_pkg::REG_CTRL: begin
               s_next.auto_ack_receive_mode = avm_req.writedata[fhp_pkg::CTRL_AACK];
               s_next.auto_retry_transmit_mode = avm_req.writedata[fhp_pkg::CTRL_ARET];
               s_next.reserved_type_upload_enable = avm_req.writedata[fhp_pkg::CTRL_UPLD];
               s_next.ack_pending_value = avm_req.writedata[fhp_pkg::CTRL_PEND];
               s_next.version_accept_mode = avm_req.writedata[fhp_pkg::CTRL_FVN_LSB +: 2];
               if (avm_req.writedata[fhp_pkg::CTRL_PTR_CLR]) begin
                  s_next.rd_ptr = 7'h00;
                  s_next.wr_ptr = 7'h00;
               end
               // start sending the buffer, phr first
               if (avm_req.writedata[fhp_pkg::CTRL_TX_GO] && s_reg.state == fhp_pkg::ST_IDLE) begin
                  s_next.state = fhp_pkg::ST_TX_SEND;
                  s_next.tx_idx = 7'h00;
                  s_next.tx.valid = 1'b1;
                  s_next.tx.first = 1'b1;
                  s_next.tx.data = s_reg.mem[0];
               end
            end
            fhp_pkg::REG_STATUS: begin
               // write one to clear
               s_next.rx_done = s_reg.rx_done & ~avm_req.writedata[fhp_pkg::ST_RX_DONE];
               s_next.tx_done = s_reg.tx_done & ~avm_req.writedata[fhp_pkg::ST_TX_DONE];
               s_next.ack_ok = s_reg.ack_ok & ~avm_req.writedata[fhp_pkg::ST_ACK_OK];
               s_next.no_ack = s_reg.no_ack & ~avm_req.writedata[fhp_pkg::ST_NO_ACK];
            end
            fhp_pkg::REG_DATA: begin
               // first byte after a pointer clear is the length octet
               s_next.mem[s_reg.wr_ptr] = avm_req.writedata[7:0];
               s_next.wr_ptr = 7'(s_reg.wr_ptr + 7'h01);
            end
            fhp_pkg::REG_PAN: s_next.pan_id = avm_req.writedata[15:0];
            fhp_pkg::REG_SHORT: s_next.short_addr = avm_req.writedata[15:0];
            fhp_pkg::REG_EXT_LO: s_next.ext_addr[31:0] = avm_req.writedata;
            fhp_pkg::REG_EXT_HI: s_next.ext_addr[63:32] = avm_req.writedata;
            default: s_next.ext_addr = s_reg.ext_addr; // unmapped write ignored
         endcase
      end

      case (s_reg.state)
         fhp_pkg::ST_IDLE, fhp_pkg::ST_ACK_WAIT: begin
            if (s_reg.state == fhp_pkg::ST_ACK_WAIT) begin
               if (s_reg.timer == 16'h0000) begin
                  s_next.state = fhp_pkg::ST_IDLE;
                  s_next.aret_wait = 1'b0;
                  s_next.no_ack = 1'b1;
                  s_next.tx_done = 1'b1;
               end else begin
                  s_next.timer = 16'(s_reg.timer - 16'h0001);
               end
            end
            // zero length is an invalid phr and is never signalled
            if (rx_in.valid && rx_in.first && rx_in.data[6:0] != 7'h00) begin
               s_next.mem[0] = rx_in.data;
               s_next.rx_len = rx_in.data[6:0];
               s_next.rx_cnt = 7'h00;
               s_next.rx_start = 1'b1;
               s_next.state = fhp_pkg::ST_RX_BODY;
            end
         end
         fhp_pkg::ST_RX_BODY: begin
            if (rx_in.valid) begin
               s_next.mem[7'(s_reg.rx_cnt + 7'h01)] = rx_in.data;
               s_next.rx_cnt = 7'(s_reg.rx_cnt + 7'h01);
               if (7'(s_reg.rx_cnt + 7'h01) == s_reg.rx_len) begin
                  s_next.state = fhp_pkg::ST_RX_EVAL;
               end
            end
         end
         fhp_pkg::ST_RX_EVAL: begin
            if (s_reg.aret_wait) begin
               // only a matching ack ends the wait; anything else is dropped
               if (s_reg.rx_len == fhp_pkg::LEN_ACK && ftype == fhp_pkg::TYPE_ACK
                     && s_reg.mem[fhp_pkg::IDX_SEQ] == s_reg.tx_seq) begin
                  s_next.state = fhp_pkg::ST_IDLE;
                  s_next.aret_wait = 1'b0;
                  s_next.ack_ok = 1'b1;
                  s_next.tx_done = 1'b1;
               end else begin
                  s_next.state = fhp_pkg::ST_ACK_WAIT;
               end
            end else begin
               s_next.state = fhp_pkg::ST_IDLE;
               if (pass) begin
                  s_next.rx_frame = 1'b1;
                  s_next.rx_done = 1'b1;
                  s_next.len_class = fhp_len_class(s_reg.rx_len);
                  s_next.last_fcf = fcf;
                  s_next.last_seq = s_reg.mem[fhp_pkg::IDX_SEQ];
                  s_next.rd_ptr = 7'h00;
               end
               // ack sent straight after the frame, well inside the turnaround
               if (want_ack) begin
                  s_next.ack.req = 1'b1;
                  s_next.ack.fcf = 16'h0000;
                  s_next.ack.fcf[2:0] = fhp_pkg::TYPE_ACK;
                  s_next.ack.fcf[fhp_pkg::FCF_PEND] =
                     s_reg.ack_pending_value & data_req;
                  s_next.ack.fcf[fhp_pkg::FCF_VER_LSB +: 2] = 2'h0;
                  s_next.ack.seq = s_reg.mem[fhp_pkg::IDX_SEQ];
               end
            end
         end
         fhp_pkg::ST_TX_SEND: begin
            if (tx_ready && s_reg.tx.valid) begin
               s_next.tx.first = 1'b0;
               // phr plus low seven bits worth of psdu; bit 7 goes out untouched
               if (s_reg.tx_idx == s_reg.mem[0][6:0]) begin
                  s_next.tx.valid = 1'b0;
                  if (s_reg.auto_retry_transmit_mode
                        && s_reg.mem[fhp_pkg::IDX_FCF_LO][fhp_pkg::FCF_ACK_REQ]) begin
                     s_next.state = fhp_pkg::ST_ACK_WAIT;
                     s_next.aret_wait = 1'b1;
                     s_next.timer = 16'(ACK_WAIT_CYCLES);
                     s_next.tx_seq = s_reg.mem[fhp_pkg::IDX_SEQ];
                  end else begin
                     s_next.state = fhp_pkg::ST_IDLE;
                     s_next.tx_done = 1'b1;
                  end
               end else begin
                  s_next.tx_idx = 7'(s_reg.tx_idx + 7'h01);
                  s_next.tx.data = s_reg.mem[7'(s_reg.tx_idx + 7'h01)];
               end
            end
         end
         default: s_next.state = fhp_pkg::ST_IDLE;
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.state <= fhp_pkg::ST_IDLE;
         s_reg.waitreq <= 1'b1;
         s_reg.version_accept_mode <= fhp_pkg::FVN_MODE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state flops
   assign avm_readdata = s_reg.rdata;
   assign avm_waitrequest = s_reg.waitreq;
   assign tx_out = s_reg.tx;
   assign ack_out = s_reg.ack;
   assign rx_start_pulse = s_reg.rx_start;
   assign rx_frame_pulse = s_reg.rx_frame;

endmodule

// File: tb/fhp_checker.sv
// concurrent checks on the ports of the frame header parser
`timescale 1ns/1ps
module fhp_checker #(
   parameter int ACK_WAIT_CYCLES = fhp_pkg::ACK_WAIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire fhp_pkg::fhp_avm_req_s avm_req,
   input wire logic [31:0] avm_readdata,
   input wire logic avm_waitrequest,
   input wire fhp_pkg::fhp_byte_s rx_in,
   input wire fhp_pkg::fhp_byte_s tx_out,
   input wire logic tx_ready,
   input wire fhp_pkg::fhp_ack_s ack_out,
   input wire logic rx_start_pulse,
   input wire logic rx_frame_pulse
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // bus answers one cycle after a request rises, then waits again
   a_bus_answer: assert property ($rose(avm_req.read | avm_req.write) |=> !avm_waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_bus_one_cycle: assert property (!avm_waitrequest |=> avm_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_start_cause: assert property (rx_start_pulse |->
      $past(rx_in.valid && rx_in.first && rx_in.data[6:0] != 7'h00))
      else $error("start pulse without a valid length octet");
   a_zero_length: assert property (rx_in.valid && rx_in.first && rx_in.data[6:0] == 7'h00
      |=> !rx_start_pulse) else $error("zero length octet reported");
   a_start_once: assert property (rx_start_pulse |=> !rx_start_pulse)
      else $error("start pulse longer than one cycle");
   a_ack_fields: assert property (ack_out.req |->
      ack_out.fcf[13:12] == 2'h0 && ack_out.fcf[2:0] == fhp_pkg::TYPE_ACK)
      else $error("generated ack has wrong type or version");
   a_ack_reported: assert property (ack_out.req |-> rx_frame_pulse)
      else $error("ack without an accepted frame");
   a_tx_hold: assert property (tx_out.valid && !tx_ready |=>
      tx_out.valid && $stable(tx_out.data) && $stable(tx_out.first))
      else $error("transmit byte dropped before it was taken");
endmodule
bind fhp_frame_header_parser fhp_checker #(.ACK_WAIT_CYCLES(ACK_WAIT_CYCLES)) chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .avm_req(avm_req), .avm_readdata(avm_readdata),
   .avm_waitrequest(avm_waitrequest), .rx_in(rx_in), .tx_out(tx_out), .tx_ready(tx_ready),
   .ack_out(ack_out), .rx_start_pulse(rx_start_pulse), .rx_frame_pulse(rx_frame_pulse));

// File: tb/fhp_radio_model.sv
// radio core stand-in: feeds received bytes, takes transmit bytes
`timescale 1ns/1ps
module fhp_radio_model (
   input wire logic ref_clk,
   input wire fhp_pkg::fhp_byte_s tx_in,
   input wire logic slow,
   output fhp_pkg::fhp_byte_s rx_out,
   output logic tx_ready
);
   // each taken byte with its first marker on top
   logic [8:0] got[$];
   logic [1:0] tick = 2'h0;
   initial begin
      rx_out = '0;
      tx_ready = 1'b0;
   end
   // slow mode takes one byte in four cycles to stretch the hold
   always @(posedge ref_clk) begin
      tick <= tick + 2'h1;
      tx_ready <= !slow || tick == 2'h3;
      if (tx_in.valid === 1'b1 && tx_ready) got.push_back({tx_in.first, tx_in.data});
   end
   // one strobed byte, then idle data inverted so no stale byte lingers
   task automatic send(input logic first, input logic [7:0] d);
      @(posedge ref_clk);
      rx_out <= '{1'b1, first, d};
      @(posedge ref_clk);
      rx_out <= '{1'b0, 1'b0, ~d};
   endtask
endmodule

// File: tb/fhp_frame_header_parser_tb.sv
// self-checking bench: header decode, filter, auto ack and retry transmit
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch at %0t got %h expected %h", $time, a, e); end end
module fhp_frame_header_parser_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   fhp_pkg::fhp_avm_req_s req = '0;
   fhp_pkg::fhp_byte_s rx_in, tx_out;
   fhp_pkg::fhp_ack_s ack_out;
   logic [31:0] rdata, q;
   logic [23:0] ack_cap = '0;
   logic wreq, tx_ready, rx_start_pulse, rx_frame_pulse;
   int err_count = 0, n_checks = 0, n_start = 0, n_frame = 0, n_ack = 0, n0;
   initial forever #10 ref_clk = ~ref_clk;
   fhp_frame_header_parser #(.ACK_WAIT_CYCLES(200)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .avm_req(req), .avm_readdata(rdata), .avm_waitrequest(wreq), .rx_in(rx_in),
      .tx_out(tx_out), .tx_ready(tx_ready), .ack_out(ack_out),
      .rx_start_pulse(rx_start_pulse), .rx_frame_pulse(rx_frame_pulse));
   fhp_radio_model radio (.ref_clk(ref_clk), .tx_in(tx_out), .slow(slow), .rx_out(rx_in),
      .tx_ready(tx_ready));
   // tally the one-cycle event outputs
   always @(posedge ref_clk) begin
      if (rx_start_pulse === 1'b1) n_start++;
      if (rx_frame_pulse === 1'b1) n_frame++;
      if (ack_out.req === 1'b1) begin
         n_ack++;
         ack_cap <= {ack_out.seq, ack_out.fcf};
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one avalon access; request held until waitrequest is seen low
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{!wr, wr, a, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      req <= '0;
      if (n >= 50) begin
         err_count++;
         print_verdict();
      end
   endtask
   // whole frame, length octet first; pulses settle two cycles after
   task automatic frame(input logic [7:0] b[$]);
      foreach (b[i]) radio.send(i == 0, b[i]);
      repeat (4) @(posedge ref_clk);
   endtask
   initial begin
      repeat (50000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      acc(0, fhp_pkg::REG_CTRL, 0); `CHK(q, 32'h10)
      acc(0, 8'h40, 0); `CHK(q, 32'h0)
      $display("test reset done");
      frame('{8'h85, 8'h02, 8'h00, 8'h5a, 8'hc1, 8'hc2}); `CHK(n_start, 1)
      acc(0, fhp_pkg::REG_STATUS, 0); `CHK(q, 32'h05)
      acc(0, fhp_pkg::REG_FCF, 0); `CHK(q, 32'h5a0002)
      acc(0, fhp_pkg::REG_DATA, 0); `CHK(q, 32'h85)
      acc(0, fhp_pkg::REG_DATA, 0); `CHK(q, 32'h02)
      frame('{8'h80}); `CHK(n_start, 1)
      $display("test length done");
      acc(1, fhp_pkg::REG_CTRL, 32'h19);
      acc(1, fhp_pkg::REG_PAN, 32'h1234);
      acc(1, fhp_pkg::REG_SHORT, 32'hbeef);
      for (int v = 0; v < 4; v++) begin
         frame('{8'h0a, 8'h23, 8'h08 | 8'(v << 4), 8'h30 + 8'(v), 8'h34, 8'h12, 8'hef, 8'hbe,
            8'h04, 8'h00, 8'h00});
         `CHK(n_ack, (v < 2) ? v + 1 : 2)
         if (v < 2) `CHK(ack_cap, {8'h30 + 8'(v), 16'h0012})
      end
      n0 = n_frame;
      frame('{8'h0a, 8'h21, 8'h08, 8'h40, 8'h34, 8'h12, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00});
      `CHK(n_ack, 2)
      frame('{8'h0a, 8'h05, 8'h08, 8'h41, 8'h34, 8'h12, 8'hef, 8'hbe, 8'h00, 8'h00, 8'h00});
      `CHK(n_frame, n0 + 1)
      acc(1, fhp_pkg::REG_CTRL, 32'h1d);
      frame('{8'h0a, 8'h05, 8'h08, 8'h42, 8'h34, 8'h12, 8'hef, 8'hbe, 8'h00, 8'h00, 8'h00});
      `CHK(n_frame, n0 + 2)
      $display("test filter done");
      acc(1, fhp_pkg::REG_CTRL, 32'h80);
      slow <= 1'b1;
      radio.got.delete();
      acc(1, fhp_pkg::REG_DATA, 32'h05);
      acc(1, fhp_pkg::REG_DATA, 32'h21);
      acc(1, fhp_pkg::REG_DATA, 32'h00);
      acc(1, fhp_pkg::REG_DATA, 32'h77);
      acc(1, fhp_pkg::REG_DATA, 32'haa);
      acc(1, fhp_pkg::REG_DATA, 32'hbb);
      acc(1, fhp_pkg::REG_CTRL, 32'h42);
      // poll from a clean value so a stale read cannot end the wait
      q = 32'h0000_0000;
      for (int n = 0; n < 200 && q[3] !== 1'b1; n++) acc(0, fhp_pkg::REG_STATUS, 0);
      `CHK(q & 32'h38, 32'h28)
      `CHK(radio.got.size(), 6)
      `CHK(radio.got[0], 9'h105)
      `CHK(radio.got[1], 9'h021)
      $display("test transmit done");
      print_verdict();
   end
endmodule
